// File: core/cdi_pkg.sv
// cdi_pkg: constants, carriers and types of the character display
// instruction decoder; assumes a single 250 MHz APB clock
package cdi_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLEAR_TIME_NS = 6200000;
    localparam int CLEAR_CYCLES  = CLEAR_TIME_NS / CLK_PERIOD_NS;
    localparam int EXEC_CYCLES   = 2;
    localparam int CNT_W         = 21;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_DATA  = 8'h04;
    localparam logic [7:0] OFS_MODE  = 8'h08;

    // ----------------------------------------------------------------
    // instruction fields
    // ----------------------------------------------------------------
    localparam int BIT_ENTRY_DIR   = 1;
    localparam int BIT_ENTRY_SHIFT = 0;
    localparam int BIT_DISP_ON     = 2;
    localparam int BIT_CURSOR_ON   = 1;
    localparam int BIT_BLINK       = 0;
    localparam int BIT_SHIFT_SEL   = 3;
    localparam int BIT_RIGHT       = 2;
    localparam int BIT_GRAPHIC     = 3;
    localparam int BIT_POWER       = 2;
    localparam int BIT_WIDTH       = 4;
    localparam int BIT_LINES       = 3;
    localparam int BIT_FONT        = 2;
    localparam logic [7:0] BLANK_CHAR = 8'h20;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       display_on;
        logic       cursor_on;
        logic       cursor_blink;
        logic       inc_dir;
        logic       shift_en;
        logic       graphic_mode;
        logic       power_on;
        logic       bus_width_sel;
        logic       two_lines;
        logic       big_font;
        logic [1:0] font_table;
    } cdi_flags_type;

    localparam cdi_flags_type FLAGS_RESET = cdi_flags_type'(12'h110);

    typedef enum logic [1:0] {
        CDI_IDLE  = 2'b00,
        CDI_EXEC  = 2'b01,
        CDI_CLEAR = 2'b10
    } cdi_state_type;

    typedef enum logic [3:0] {
        CMD_NONE  = 4'h0,
        CMD_CLEAR = 4'h1,
        CMD_HOME  = 4'h2,
        CMD_ENTRY = 4'h3,
        CMD_DISP  = 4'h4,
        CMD_MOVE  = 4'h5,
        CMD_GMODE = 4'h6,
        CMD_FUNC  = 4'h7,
        CMD_GLYPH = 4'h8,
        CMD_DRAM  = 4'h9
    } cdi_cmd_type;

endpackage

// File: core/cdi_ram.sv
// cdi_ram: flip-flop byte store, one write port, one read port
// assumes write controls come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module cdi_ram import cdi_pkg::*; #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem[i] <= '0;
            end
        end else if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule
`default_nettype wire

// File: core/cdi_decoder.sv
// cdi_decoder: instruction decoder of a character display controller
// assumes an APB master on pclk; scan and drive logic sit outside
//
// Function
// - Instruction 0x01 blanks the display RAM and zeroes the address counter within the clear time.
// - Return home zeroes the address counter and the display shift and keeps display RAM.
// - Entry mode latches cursor direction from bit 1 and display shift enable from bit 0.
// - Display control latches display on, cursor visible and cursor blink from bits 2, 1, 0.
// - The bit-4 command with bits 1:0 zero moves the cursor or shifts the display, left or right.
// - The bit-4 command with bits 1:0 both one latches graphic mode and power flags from bits 3, 2.
// - Function set latches bus width, line count, font size and the two font table bits.
// - The bit-6 command loads a six-bit glyph RAM address and selects glyph RAM for data.
// - The bit-7 command loads a seven-bit display RAM address and selects display RAM for data.
// - An instruction read returns busy on bit 7 and the address counter on bits 6:0.
// - A data write stores the byte into the selected RAM at the address counter.
// - A data read returns the selected RAM byte at the address counter.
// - Each data read or write steps the address counter by one in the latched direction.
// - While busy only the busy and address read and the mode register read are taken; the host waits for busy low.
`timescale 1ns/1ns
`default_nettype none
module cdi_decoder import cdi_pkg::*; #(
    parameter int CLEAR_CNT = CLEAR_CYCLES,
    parameter int EXEC_CNT  = EXEC_CYCLES
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    output cdi_flags_type      mode_flags,
    output logic      [6:0]    addr_counter,
    output logic      [6:0]    shift_offset,
    output logic               glyph_sel,
    output logic               busy_flag
);

    cdi_state_type    state;
    cdi_state_type    next_state;
    cdi_cmd_type      cmd;
    logic [CNT_W-1:0] exec_cnt;
    logic [6:0]       clr_ptr;
    logic             nib_phase;
    logic [3:0]       nib_hold;
    logic [7:0]       wbyte;
    logic [7:0]       rbyte;
    logic [7:0]       d_rd;
    logic [7:0]       g_rd;
    logic [6:0]       ac_step;
    logic             setup;
    logic             acc;
    logic             is_instr;
    logic             is_data;
    logic             is_mode;
    logic             mapped;
    logic             refused;
    logic             err;
    logic             go;
    logic             nib_mode;
    logic             complete;
    logic             instr_wr;
    logic             data_wr;
    logic             data_rd;
    logic             d_we;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign setup    = psel & penable & ~pready;
    assign acc      = psel & penable & pready;
    assign is_instr = paddr == OFS_INSTR;
    assign is_data  = paddr == OFS_DATA;
    assign is_mode  = paddr == OFS_MODE;
    assign mapped   = is_instr | is_data | (is_mode & ~pwrite);
    assign refused  = busy_flag & ~(~pwrite & (is_instr | is_mode));
    assign err      = ~mapped | refused;
    assign go       = acc & ~pslverr;
    assign nib_mode = ~mode_flags.bus_width_sel;
    assign complete = go & (~nib_mode | nib_phase);
    assign instr_wr = complete & pwrite & is_instr;
    assign data_wr  = complete & pwrite & is_data;
    assign data_rd  = complete & ~pwrite & is_data;
    assign wbyte    = nib_mode ? {nib_hold, pwdata[7:4]} : pwdata[7:0];
    assign ac_step  = mode_flags.inc_dir ? addr_counter + 7'h01
                                         : addr_counter - 7'h01;

    // ----------------------------------------------------------------
    // instruction classes
    // ----------------------------------------------------------------
    always_comb begin
        cmd = CMD_NONE;
        casez (wbyte)
            8'b0000_0001: cmd = CMD_CLEAR;
            8'b0000_001?: cmd = CMD_HOME;
            8'b0000_01??: cmd = CMD_ENTRY;
            8'b0000_1???: cmd = CMD_DISP;
            8'b0001_??00: cmd = CMD_MOVE;
            8'b0001_??11: cmd = CMD_GMODE;
            8'b001?_????: cmd = CMD_FUNC;
            8'b01??_????: cmd = CMD_GLYPH;
            8'b1???_????: cmd = CMD_DRAM;
            default:      cmd = CMD_NONE;
        endcase
    end

    // ----------------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup & err;
        end
    end

    always_comb begin
        if (is_instr) begin
            rbyte = {busy_flag, addr_counter};
        end else if (glyph_sel) begin
            rbyte = g_rd;
        end else begin
            rbyte = d_rd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup) begin
            if (err | pwrite) begin
                prdata <= 32'h0;
            end else if (is_mode) begin
                prdata <= {11'h0, nib_phase, shift_offset, glyph_sel,
                           mode_flags};
            end else if (nib_mode) begin
                prdata <= {24'h0, nib_phase ? rbyte[3:0] : rbyte[7:4],
                           4'h0};
            end else begin
                prdata <= {24'h0, rbyte};
            end
        end
    end

    // ----------------------------------------------------------------
    // nibble pairing
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nib_phase <= 1'b0;
            nib_hold  <= 4'h0;
        end else if (go & nib_mode & (is_instr | is_data)) begin
            nib_phase <= ~nib_phase;
            if (pwrite & ~nib_phase) begin
                nib_hold <= pwdata[7:4];
            end
        end else if (~nib_mode) begin
            nib_phase <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // execution sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            CDI_IDLE: begin
                if (instr_wr & (cmd == CMD_CLEAR)) begin
                    next_state = CDI_CLEAR;
                end else if (instr_wr | data_wr | data_rd) begin
                    next_state = CDI_EXEC;
                end
            end
            CDI_EXEC, CDI_CLEAR: begin
                if (exec_cnt == '0) begin
                    next_state = CDI_IDLE;
                end
            end
            default: next_state = CDI_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= CDI_IDLE;
            busy_flag <= 1'b0;
        end else begin
            state     <= next_state;
            busy_flag <= next_state != CDI_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_cnt <= '0;
        end else if (state == CDI_IDLE) begin
            if (next_state == CDI_CLEAR) begin
                exec_cnt <= CNT_W'(CLEAR_CNT - 1);
            end else begin
                exec_cnt <= CNT_W'(EXEC_CNT - 1);
            end
        end else if (exec_cnt != '0) begin
            exec_cnt <= exec_cnt - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_ptr <= 7'h0;
        end else if (state == CDI_CLEAR) begin
            clr_ptr <= clr_ptr + 7'h01;
        end else begin
            clr_ptr <= 7'h0;
        end
    end

    // ----------------------------------------------------------------
    // address counter and display shift
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_counter <= 7'h0;
        end else if (instr_wr) begin
            unique case (cmd)
                CMD_CLEAR, CMD_HOME: addr_counter <= 7'h0;
                CMD_MOVE: begin
                    if (!wbyte[BIT_SHIFT_SEL]) begin
                        addr_counter <= wbyte[BIT_RIGHT]
                            ? addr_counter + 7'h01
                            : addr_counter - 7'h01;
                    end
                end
                CMD_GLYPH: addr_counter <= {1'b0, wbyte[5:0]};
                CMD_DRAM:  addr_counter <= wbyte[6:0];
                default:   addr_counter <= addr_counter;
            endcase
        end else if (data_wr | data_rd) begin
            addr_counter <= ac_step;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_offset <= 7'h0;
        end else if (instr_wr & ((cmd == CMD_CLEAR) | (cmd == CMD_HOME))) begin
            shift_offset <= 7'h0;
        end else if (instr_wr & (cmd == CMD_MOVE) & wbyte[BIT_SHIFT_SEL]) begin
            shift_offset <= wbyte[BIT_RIGHT] ? shift_offset + 7'h01
                                             : shift_offset - 7'h01;
        end else if ((data_wr | data_rd) & mode_flags.shift_en) begin
            shift_offset <= mode_flags.inc_dir ? shift_offset - 7'h01
                                               : shift_offset + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glyph_sel <= 1'b0;
        end else if (instr_wr) begin
            if (cmd == CMD_GLYPH) begin
                glyph_sel <= 1'b1;
            end else if ((cmd == CMD_DRAM) | (cmd == CMD_CLEAR)
                         | (cmd == CMD_HOME)) begin
                glyph_sel <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // mode flags
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_flags <= FLAGS_RESET;
        end else if (instr_wr) begin
            unique case (cmd)
                CMD_ENTRY: begin
                    mode_flags.inc_dir  <= wbyte[BIT_ENTRY_DIR];
                    mode_flags.shift_en <= wbyte[BIT_ENTRY_SHIFT];
                end
                CMD_DISP: begin
                    mode_flags.display_on   <= wbyte[BIT_DISP_ON];
                    mode_flags.cursor_on    <= wbyte[BIT_CURSOR_ON];
                    mode_flags.cursor_blink <= wbyte[BIT_BLINK];
                end
                CMD_GMODE: begin
                    mode_flags.graphic_mode <= wbyte[BIT_GRAPHIC];
                    mode_flags.power_on     <= wbyte[BIT_POWER];
                end
                CMD_FUNC: begin
                    mode_flags.bus_width_sel <= wbyte[BIT_WIDTH];
                    mode_flags.two_lines     <= wbyte[BIT_LINES];
                    mode_flags.big_font      <= wbyte[BIT_FONT];
                    mode_flags.font_table    <= wbyte[1:0];
                end
                default: mode_flags <= mode_flags;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // character stores
    // ----------------------------------------------------------------
    assign d_we = (data_wr & ~glyph_sel) | (state == CDI_CLEAR);

    cdi_ram #(.AW(7), .DW(8)) u_display_ram (
        .clk   (pclk),
        .rst_n (presetn),
        .we    (d_we),
        .waddr ((state == CDI_CLEAR) ? clr_ptr : addr_counter),
        .wdata ((state == CDI_CLEAR) ? BLANK_CHAR : wbyte),
        .raddr (addr_counter),
        .rdata (d_rd)
    );

    cdi_ram #(.AW(6), .DW(8)) u_glyph_ram (
        .clk   (pclk),
        .rst_n (presetn),
        .we    (data_wr & glyph_sel),
        .waddr (addr_counter[5:0]),
        .wdata (wbyte),
        .raddr (addr_counter[5:0]),
        .rdata (g_rd)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_instr(cdi_cmd_type c);
        instr_wr && (cmd == c);
    endsequence

    sequence s_data_op;
        (data_wr || data_rd) && !busy_flag;
    endsequence

    AST_CLEAR_AC: assert property (s_instr(CMD_CLEAR) |=>
        (addr_counter == 7'h0) && busy_flag && (state == CDI_CLEAR))
        else $error("clear did not zero counter or raise busy");
    AST_HOME: assert property (s_instr(CMD_HOME) |=>
        (addr_counter == 7'h0) && (shift_offset == 7'h0) && !glyph_sel)
        else $error("home did not reset counter and shift");
    AST_ENTRY: assert property (s_instr(CMD_ENTRY) |=>
        mode_flags.inc_dir == $past(wbyte[BIT_ENTRY_DIR]))
        else $error("entry mode direction not latched");
    AST_DISP: assert property (s_instr(CMD_DISP) |=>
        mode_flags.display_on == $past(wbyte[BIT_DISP_ON]))
        else $error("display on flag not latched");
    AST_MOVE: assert property (s_instr(CMD_MOVE) |=>
        addr_counter == ($past(wbyte[BIT_SHIFT_SEL]) ? $past(addr_counter)
        : $past(wbyte[BIT_RIGHT]) ? $past(addr_counter) + 7'h01
        : $past(addr_counter) - 7'h01))
        else $error("cursor move wrong");
    AST_GMODE: assert property (s_instr(CMD_GMODE) |=>
        mode_flags.power_on == $past(wbyte[BIT_POWER]))
        else $error("power flag not latched");
    AST_FUNC: assert property (s_instr(CMD_FUNC) |=>
        mode_flags.font_table == $past(wbyte[1:0]))
        else $error("font table not latched");
    AST_GLYPH: assert property (s_instr(CMD_GLYPH) |=>
        glyph_sel && (addr_counter == {1'b0, $past(wbyte[5:0])}))
        else $error("glyph address not loaded");
    AST_DRAM: assert property (s_instr(CMD_DRAM) |=>
        !glyph_sel && (addr_counter == $past(wbyte[6:0])))
        else $error("display address not loaded");
    AST_STATUS: assert property ((setup && is_instr && !pwrite &&
        !err && !nib_mode) |=> prdata[7:0] == {$past(busy_flag),
        $past(addr_counter)})
        else $error("status read mismatch");
    AST_STEP: assert property (s_data_op |=>
        (addr_counter == $past(ac_step)) && busy_flag)
        else $error("address counter did not step");
    AST_BUSY_REFUSE: assert property ((setup && busy_flag && pwrite) |=>
        pslverr && pready)
        else $error("write while busy not refused");
    AST_BUSY_LEN: assert property ((s_instr(CMD_ENTRY) or
        s_instr(CMD_DISP)) |=> busy_flag [*2] ##1 !busy_flag)
        else $error("busy length wrong");
    AST_NIBBLE: assert property ((go && nib_mode && is_data &&
        pwrite && !nib_phase) |=> nib_phase &&
        (nib_hold == $past(pwdata[7:4])))
        else $error("high nibble not held");

endmodule
`default_nettype wire

// File: verification/cdi_host.sv
// cdi_host: apb master standing in for the host processor
// assumes pclk from the bench and the decoder as apb slave
`timescale 1ns/1ns
`default_nettype none
module cdi_host import cdi_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic      [7:0]  paddr = 8'h00,
    output logic      [31:0] pwdata = 32'h0
);
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
              output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task ready;
        logic [31:0] rd;
        logic        err;
        rd = 32'h80;
        while (rd[7] !== 1'b0) xfer(1'b0, OFS_INSTR, 8'h00, rd, err);
    endtask
    task op(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [31:0] rd, output logic err);
        logic [7:0] v;
        v = d;
        if (w && a == OFS_INSTR && v[7:1] == 7'h01) v[0] = 1'b0;
        ready();
        xfer(w, a, v, rd, err);
    endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// testbench: decoder against an integer model of the instruction set
// assumes cdi_host as bus master and a shortened clear time
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import cdi_pkg::*;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          psel, penable, pwrite, pready, pslverr;
    logic          glyph_sel, busy_flag, err;
    logic [7:0]    paddr, v;
    logic [31:0]   pwdata, prdata, rd;
    logic [6:0]    addr_counter, shift_offset, a;
    cdi_flags_type mode_flags;
    int            fails, n_tests, ac, inc, gsel, k;
    logic [7:0]    dram [128];
    logic [7:0]    gram [64];
    cdi_decoder #(.CLEAR_CNT(200), .EXEC_CNT(2)) dut_u (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_flags(mode_flags), .glyph_sel(glyph_sel),
        .addr_counter(addr_counter), .shift_offset(shift_offset),
        .busy_flag(busy_flag));
    cdi_host host_u (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    initial begin
        forever #2 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task settle;
        host_u.ready();
        @(negedge pclk);
    endtask
    task ins(input logic [7:0] c);
        host_u.op(1'b1, OFS_INSTR, c, rd, err);
        settle();
    endtask
    task wd(input logic [7:0] d);
        host_u.op(1'b1, OFS_DATA, d, rd, err);
        if (gsel) gram[ac%64] = d;
        else dram[ac] = d;
        ac = (ac + (inc ? 1 : 127)) % 128;
        settle();
        chk(addr_counter, ac);
    endtask
    task rdd;
        host_u.op(1'b0, OFS_DATA, 8'h00, rd, err);
        chk(rd[7:0], gsel ? gram[ac%64] : dram[ac]);
        ac = (ac + (inc ? 1 : 127)) % 128;
        settle();
        chk(addr_counter, ac);
    endtask
    task nib_poll;
        logic [31:0] hi;
        do begin
            host_u.xfer(1'b0, OFS_INSTR, 8'h00, hi, err);
            host_u.xfer(1'b0, OFS_INSTR, 8'h00, rd, err);
        end while (hi[7] !== 1'b0);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h1FF1));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(mode_flags, 12'h110);
        $display("test reset done");
        a = 7'($urandom);
        ins(8'h80 | a);
        ac = a;
        inc = 1;
        wd(8'($urandom));
        host_u.op(1'b1, OFS_INSTR, 8'h01, rd, err);
        host_u.xfer(1'b0, OFS_INSTR, 8'h00, rd, err);
        chk(rd[7:0], 8'h80);
        host_u.xfer(1'b1, OFS_DATA, 8'h55, rd, err);
        chk(err, 1'b1);
        settle();
        foreach (dram[i]) dram[i] = 8'h20;
        inc = 1;
        ins(8'h80 | a);
        ac = a;
        rdd();
        $display("test clear done");
        for (inc = 1; inc >= 0; inc--) begin
            ins(8'h04 | 8'(inc << 1));
            chk(mode_flags.inc_dir, inc);
            ac = inc ? 127 : 0;
            ins(8'h80 | 8'(ac));
            repeat (3) wd(8'($urandom));
            ac = inc ? 127 : 0;
            ins(8'h80 | 8'(ac));
            repeat (3) rdd();
        end
        $display("test data done");
        for (k = 0; k < 8; k++) begin
            ins(8'h08 | 8'(k));
            chk(mode_flags[11:9], k);
            v = 8'($urandom) | 8'h10;
            ins(8'h20 | v[4:0]);
            chk(mode_flags[4:0], v[4:0]);
            ins(8'h13 | 8'((k % 4) << 2));
            chk(mode_flags[6:5], k % 4);
        end
        $display("test flags done");
        ins(8'h18);
        chk(shift_offset, 7'h7F);
        v = shift_offset;
        ins(8'h14);
        chk(shift_offset, v);
        chk(addr_counter, ac + 1);
        ins(8'h03);
        chk({addr_counter, shift_offset}, 14'h0);
        inc = 0;
        ac = 0;
        rdd();
        $display("test home done");
        v = 8'($urandom) & 8'h3F;
        ins(8'h40 | v);
        chk({glyph_sel, addr_counter}, {1'b1, v[6:0]});
        gsel = 1;
        ac = v;
        wd(8'($urandom));
        ins(8'h40 | v);
        ac = v;
        rdd();
        host_u.op(1'b0, 8'h0C, 8'h00, rd, err);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        host_u.op(1'b1, OFS_MODE, 8'h00, rd, err);
        chk(err, 1'b1);
        $display("test glyph done");
        gsel = 0;
        inc = 1;
        ac = a;
        ins(8'h07);
        ins(8'h80 | a);
        host_u.op(1'b1, OFS_INSTR, 8'h2C, rd, err);
        nib_poll();
        chk(rd[7:4], a[3:0]);
        v = 8'($urandom);
        host_u.xfer(1'b1, OFS_DATA, {v[7:4], 4'h0}, rd, err);
        host_u.xfer(1'b1, OFS_DATA, {v[3:0], 4'h0}, rd, err);
        nib_poll();
        chk(rd[7:4], 4'(a + 1));
        host_u.xfer(1'b1, OFS_INSTR, 8'h30, rd, err);
        host_u.xfer(1'b1, OFS_INSTR, 8'hC0, rd, err);
        settle();
        chk(mode_flags.bus_width_sel, 1'b1);
        dram[a] = v;
        ins(8'h80 | a);
        rdd();
        chk(shift_offset, 7'h7E);
        $display("test nibble done");
        give_verdict();
    end
endmodule
`default_nettype wire
